/* rtl/bpe_port_ctrl.v */
// Purpose: Board port enables, serial line fixing and card socket gating
// Assumes: Host register port, 10 MHz clock, pins synchronised here
// Notes:   All outputs are flip-flops; enable bits are active low, supply select fields are codes
`timescale 1ns/1ps
`include "bpe_defs.vh"

module bpe_port_ctrl (
  input  wire                   i_clk,
  input  wire                   i_rst,
  input  wire [`BPE_ADDR_W-1:0] i_addr,
  input  wire [31:0]            i_wdata,
  input  wire                   i_wr,
  input  wire                   i_rd,
  output reg  [31:0]            o_rdata,
  input  wire                   i_optical_tx,
  input  wire [1:0]             i_card_present_n,
  input  wire [1:0]             i_card_voltage_sense_n,
  input  wire [1:0]             i_serial_dtr,
  output reg                    o_wired_net_xcvr_enable_n,
  output reg                    o_optical_xcvr_enable_n,
  output reg                    o_optical_range_high,
  output reg                    o_serial_port_one_enable_n,
  output reg                    o_serial_port_two_enable_n,
  output reg  [1:0]             o_serial_rx_oe,
  output reg  [1:0]             o_serial_carrier_detect,
  output reg  [1:0]             o_serial_data_set_ready,
  output reg  [1:0]             o_serial_clear_to_send,
  output reg                    o_card_port_enable_n,
  output reg                    o_card_in_buf_enable_n,
  output reg                    o_speaker_output_oe,
  output reg                    o_card_strobe_oe,
  output reg  [1:0]             o_card_supply_select,
  output reg  [1:0]             o_card_prog_supply_select
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  reg  [`BPE_CTL_W-1:0] ctrl_reg;
  reg  [`BPE_CTL_W-1:0] ctrl_next;
  reg                   inserted_reg;
  reg                   removed_reg;
  reg                   present_d_reg;
  wire [1:0]            present_n_s;
  wire [1:0]            sense_n_s;
  wire [1:0]            dtr_s;
  wire                  tx_s;
  wire                  range_high;
  wire                  setup_ok;
  wire                  wr_ctrl;
  wire                  wr_stat;
  wire                  both_present;
  wire                  chan_on;
  wire [31:0]           stat_word;
  wire [31:0]           ctrl_word;
  wire                  wired_n_bit;
  wire                  optical_n_bit;
  wire                  ser1_n_bit;
  wire                  ser2_n_bit;
  wire                  card_n_bit;
  wire [1:0]            supply_field;
  wire [1:0]            prog_field;
  wire                  ins_event;
  wire                  rem_event;
  wire                  ins_clear;
  wire                  rem_clear;
  reg  [31:0]           rdata_next;
  reg                   inserted_next;
  reg                   removed_next;
  reg                   wired_n_next;
  reg                   optical_n_next;
  reg                   range_high_next;
  reg                   ser1_n_next;
  reg                   ser2_n_next;
  reg  [1:0]            rx_oe_next;
  reg  [1:0]            cd_next;
  reg  [1:0]            dsr_next;
  reg  [1:0]            cts_next;
  reg                   card_n_next;
  reg                   in_buf_n_next;
  reg                   speaker_oe_next;
  reg                   strobe_oe_next;
  reg  [1:0]            supply_next;
  reg  [1:0]            prog_next;

  function sel;
    input [`BPE_ADDR_W-1:0] a;
    input [`BPE_ADDR_W-1:0] ofs;
    begin
      sel = (a == ofs);
    end
  endfunction

  function field_on;
    input [1:0] f;
    begin
      field_on = (f != 2'h0);
    end
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  bpe_sync #(
    .W    (7),
    .INIT (7'h0f)
  ) u_sync (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_async ({i_optical_tx, i_serial_dtr, i_card_voltage_sense_n, i_card_present_n}),
    .o_sync  ({tx_s, dtr_s, sense_n_s, present_n_s})
  );

  // ----------------------------------------------------------------
  // Optical rate range latch
  // ----------------------------------------------------------------
  bpe_ir_range u_ir_range (
    .i_clk        (i_clk),
    .i_rst        (i_rst),
    .i_en_n       (ctrl_reg[`BPE_CTL_OPTICAL_N]),
    .i_tx         (tx_s),
    .o_range_high (range_high),
    .o_setup_ok   (setup_ok)
  );

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  assign wr_ctrl      = i_wr && sel(i_addr, `BPE_OFS_CTRL);
  assign wr_stat      = i_wr && sel(i_addr, `BPE_OFS_STAT);
  assign both_present = (present_n_s == 2'b00);
  assign chan_on      = !ctrl_reg[`BPE_CTL_CARD_N];

  assign stat_word = {22'h0,
                      removed_reg,
                      inserted_reg,
                      setup_ok,
                      range_high,
                      dtr_s,
                      sense_n_s,
                      present_n_s};

  always @* begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl)
      ctrl_next = i_wdata[`BPE_CTL_W-1:0];
  end

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  assign ctrl_word     = {{(32-`BPE_CTL_W){1'b0}}, ctrl_reg};
  assign wired_n_bit   = ctrl_reg[`BPE_CTL_WIRED_N];
  assign optical_n_bit = ctrl_reg[`BPE_CTL_OPTICAL_N];
  assign ser1_n_bit    = ctrl_reg[`BPE_CTL_SER1_N];
  assign ser2_n_bit    = ctrl_reg[`BPE_CTL_SER2_N];
  assign card_n_bit    = ctrl_reg[`BPE_CTL_CARD_N];
  assign supply_field  = ctrl_reg[`BPE_CTL_SUPPLY_HI:`BPE_CTL_SUPPLY_LO];
  assign prog_field    = ctrl_reg[`BPE_CTL_PROG_HI:`BPE_CTL_PROG_LO];

  // ----------------------------------------------------------------
  // Read data select
  // ----------------------------------------------------------------
  always @* begin
    rdata_next = 32'h0;
    if (i_rd) begin
      case (i_addr)
        `BPE_OFS_CTRL: rdata_next = ctrl_word;
        `BPE_OFS_STAT: rdata_next = stat_word;
        default:       rdata_next = 32'h0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Control register and read port
  // ----------------------------------------------------------------
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_reg <= `BPE_CTL_RESET;
      o_rdata  <= 32'h0;
    end else begin
      ctrl_reg <= ctrl_next;
      o_rdata  <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // Card insertion and removal events
  // ----------------------------------------------------------------
  assign ins_event = chan_on && both_present && !present_d_reg;
  assign rem_event = chan_on && !both_present && present_d_reg;
  assign ins_clear = wr_stat && i_wdata[`BPE_ST_INSERTED];
  assign rem_clear = wr_stat && i_wdata[`BPE_ST_REMOVED];

  always @* begin
    inserted_next = inserted_reg;
    removed_next  = removed_reg;
    if (ins_event)
      inserted_next = 1'b1;
    else if (ins_clear)
      inserted_next = 1'b0;
    if (rem_event)
      removed_next = 1'b1;
    else if (rem_clear)
      removed_next = 1'b0;
  end

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      present_d_reg <= 1'b0;
      inserted_reg  <= 1'b0;
      removed_reg   <= 1'b0;
    end else begin
      present_d_reg <= both_present;
      inserted_reg  <= inserted_next;
      removed_reg   <= removed_next;
    end
  end

  // ----------------------------------------------------------------
  // Network and serial next values
  // ----------------------------------------------------------------
  always @* begin
    wired_n_next    = wired_n_bit;
    optical_n_next  = optical_n_bit;
    range_high_next = range_high;
    ser1_n_next     = ser1_n_bit;
    ser2_n_next     = ser2_n_bit;
    rx_oe_next      = ~{ser2_n_bit, ser1_n_bit};
    cd_next         = 2'h3;
    dsr_next        = o_serial_carrier_detect;
    cts_next        = 2'h3;
  end

  // ----------------------------------------------------------------
  // Card socket next values
  // ----------------------------------------------------------------
  always @* begin
    card_n_next     = card_n_bit;
    in_buf_n_next   = card_n_bit;
    speaker_oe_next = chan_on;
    strobe_oe_next  = chan_on && field_on(supply_field);
    supply_next     = supply_field;
    prog_next       = prog_field;
  end

  // ----------------------------------------------------------------
  // Output stage
  // ----------------------------------------------------------------
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_wired_net_xcvr_enable_n  <= 1'b1;
      o_optical_xcvr_enable_n    <= 1'b1;
      o_optical_range_high       <= 1'b0;
      o_serial_port_one_enable_n <= 1'b1;
      o_serial_port_two_enable_n <= 1'b1;
      o_serial_rx_oe             <= 2'h0;
      o_serial_carrier_detect    <= 2'h3;
      o_serial_data_set_ready    <= 2'h3;
      o_serial_clear_to_send     <= 2'h3;
      o_card_port_enable_n       <= 1'b1;
      o_card_in_buf_enable_n     <= 1'b1;
      o_speaker_output_oe        <= 1'b0;
      o_card_strobe_oe           <= 1'b0;
      o_card_supply_select       <= 2'h0;
      o_card_prog_supply_select  <= 2'h0;
    end else begin
      o_wired_net_xcvr_enable_n  <= wired_n_next;
      o_optical_xcvr_enable_n    <= optical_n_next;
      o_optical_range_high       <= range_high_next;
      o_serial_port_one_enable_n <= ser1_n_next;
      o_serial_port_two_enable_n <= ser2_n_next;
      o_serial_rx_oe             <= rx_oe_next;
      o_serial_carrier_detect    <= cd_next;
      o_serial_data_set_ready    <= dsr_next;
      o_serial_clear_to_send     <= cts_next;
      o_card_port_enable_n       <= card_n_next;
      o_card_in_buf_enable_n     <= in_buf_n_next;
      o_speaker_output_oe        <= speaker_oe_next;
      o_card_strobe_oe           <= strobe_oe_next;
      o_card_supply_select       <= supply_next;
      o_card_prog_supply_select  <= prog_next;
    end
  end

endmodule // bpe_port_ctrl

/* rtl/bpe_defs.vh */
// Purpose: Constants for the board port enable control block
// Assumes: 10 MHz system clock, 8-bit register address, 32-bit data
// Notes:   Offsets are byte addresses of aligned 32-bit words
`ifndef BPE_DEFS_VH
`define BPE_DEFS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define BPE_ADDR_W            8
`define BPE_OFS_CTRL          8'h04
`define BPE_OFS_STAT          8'h08

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define BPE_CTL_WIRED_N       0
`define BPE_CTL_OPTICAL_N     1
`define BPE_CTL_SER1_N        2
`define BPE_CTL_SER2_N        3
`define BPE_CTL_CARD_N        4
`define BPE_CTL_SUPPLY_LO     5
`define BPE_CTL_SUPPLY_HI     6
`define BPE_CTL_PROG_LO       7
`define BPE_CTL_PROG_HI       8
`define BPE_CTL_W             9
`define BPE_CTL_RESET         9'h01f

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define BPE_ST_PRESENT_LO     0
`define BPE_ST_SENSE_LO       2
`define BPE_ST_DTR_LO         4
`define BPE_ST_RANGE_HIGH     6
`define BPE_ST_SETUP_OK       7
`define BPE_ST_INSERTED       8
`define BPE_ST_REMOVED        9

// ----------------------------------------------------------------
// Timing and rate figures
// ----------------------------------------------------------------
`define BPE_CLK_NS            100
`define BPE_TX_SETUP_NS       200
`define BPE_TX_SETUP_CYC      ((`BPE_TX_SETUP_NS + `BPE_CLK_NS - 1) / `BPE_CLK_NS)
`define BPE_RATE_LOW_MIN      9600
`define BPE_RATE_SPLIT        1200000
`define BPE_RATE_HIGH_MAX     4000000

`endif

/* rtl/bpe_sync.v */
// Purpose: Two-flop synchroniser for a vector of pin inputs
// Assumes: Inputs are asynchronous to i_clk
// Notes:   First stage is read only by the second stage
`timescale 1ns/1ps

module bpe_sync #(
  parameter W = 1,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  input  wire         i_clk,
  input  wire         i_rst,
  input  wire [W-1:0] i_async,
  output reg  [W-1:0] o_sync
);

  reg [W-1:0] meta_reg;

  // ----------------------------------------------------------------
  // Two stages
  // ----------------------------------------------------------------
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_reg <= INIT;
      o_sync   <= INIT;
    end else begin
      meta_reg <= i_async;
      o_sync   <= meta_reg;
    end
  end

endmodule // bpe_sync

/* rtl/bpe_ir_range.v */
// Purpose: Latches the optical link rate range at enable assertion
// Assumes: i_tx is already synchronised; i_en_n is a register output
// Notes:   Setup is judged by how long tx held its level before the edge
`timescale 1ns/1ps
`include "bpe_defs.vh"

module bpe_ir_range (
  input  wire i_clk,
  input  wire i_rst,
  input  wire i_en_n,
  input  wire i_tx,
  output reg  o_range_high,
  output reg  o_setup_ok
);

  reg       en_n_d_reg;
  reg       tx_d_reg;
  reg [1:0] stable_reg;

  // ----------------------------------------------------------------
  // Stability count and edge latch
  // ----------------------------------------------------------------
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      en_n_d_reg   <= 1'b1;
      tx_d_reg     <= 1'b0;
      stable_reg   <= 2'h0;
      o_range_high <= 1'b0;
      o_setup_ok   <= 1'b0;
    end else begin
      en_n_d_reg <= i_en_n;
      tx_d_reg   <= i_tx;
      if (i_tx != tx_d_reg)
        stable_reg <= 2'h0;
      else if (stable_reg != 2'h3)
        stable_reg <= stable_reg + 2'h1;
      if (en_n_d_reg && !i_en_n) begin
        o_range_high <= i_tx;
        o_setup_ok   <= ({30'h0, stable_reg} >= `BPE_TX_SETUP_CYC);
      end
    end
  end

endmodule // bpe_ir_range

/* verif/bpe_port_ctrl_asserts.sv */
// Purpose: Checker for the board port enable control outputs
// Assumes: Bound to bpe_port_ctrl, single clock domain
// Notes:   Outputs follow a control write two edges later
`timescale 1ns/1ps
`include "bpe_defs.vh"

module bpe_port_ctrl_asserts (
  input wire                   i_clk,
  input wire                   i_rst,
  input wire [`BPE_ADDR_W-1:0] i_addr,
  input wire [31:0]            i_wdata,
  input wire                   i_wr,
  input wire                   i_rd,
  input wire [31:0]            o_rdata,
  input wire                   o_wired_net_xcvr_enable_n,
  input wire                   o_optical_xcvr_enable_n,
  input wire                   o_serial_port_one_enable_n,
  input wire                   o_serial_port_two_enable_n,
  input wire [1:0]             o_serial_rx_oe,
  input wire [1:0]             o_serial_carrier_detect,
  input wire [1:0]             o_serial_data_set_ready,
  input wire [1:0]             o_serial_clear_to_send,
  input wire                   o_card_port_enable_n,
  input wire                   o_card_in_buf_enable_n,
  input wire                   o_speaker_output_oe,
  input wire                   o_card_strobe_oe,
  input wire [1:0]             o_card_supply_select,
  input wire [1:0]             o_card_prog_supply_select
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence s_ctrl_wr;
    i_wr && i_addr == `BPE_OFS_CTRL;
  endsequence
  sequence s_odd_rd;
    i_rd && i_addr != `BPE_OFS_CTRL && i_addr != `BPE_OFS_STAT;
  endsequence
  property p_wired;
    s_ctrl_wr |-> ##2 o_wired_net_xcvr_enable_n == $past(i_wdata[0], 2);
  endproperty
  property p_opt;
    s_ctrl_wr |-> ##2 o_optical_xcvr_enable_n == $past(i_wdata[1], 2);
  endproperty
  property p_ser;
    s_ctrl_wr |-> ##2 {o_serial_port_two_enable_n, o_serial_port_one_enable_n} == $past(i_wdata[3:2], 2);
  endproperty
  property p_sup;
    s_ctrl_wr |-> ##2 {o_card_prog_supply_select, o_card_supply_select} == $past(i_wdata[8:5], 2);
  endproperty
  property p_rx;
    o_serial_rx_oe == ~{o_serial_port_two_enable_n, o_serial_port_one_enable_n};
  endproperty
  property p_fixed;
    o_serial_carrier_detect == 2'h3 && o_serial_clear_to_send == 2'h3 && o_serial_data_set_ready == o_serial_carrier_detect;
  endproperty
  property p_buf;
    o_speaker_output_oe != o_card_port_enable_n && o_card_in_buf_enable_n == o_card_port_enable_n;
  endproperty
  property p_strobe;
    o_card_strobe_oe == (!o_card_port_enable_n && o_card_supply_select != 2'h0);
  endproperty
  property p_idle;
    !i_rd |=> o_rdata == 32'h0;
  endproperty
  property p_odd;
    s_odd_rd |=> o_rdata == 32'h0;
  endproperty
  a_wired: assert property (p_wired) else $error("wired enable mismatch");
  a_opt: assert property (p_opt) else $error("optical enable mismatch");
  a_ser: assert property (p_ser) else $error("serial enable mismatch");
  a_sup: assert property (p_sup) else $error("supply select mismatch");
  a_rx: assert property (p_rx) else $error("receiver release mismatch");
  a_fixed: assert property (p_fixed) else $error("fixed modem lines wrong");
  a_buf: assert property (p_buf) else $error("card buffer gating wrong");
  a_strobe: assert property (p_strobe) else $error("strobe drive without supply");
  a_idle: assert property (p_idle) else $error("read data outside read slot");
  a_odd: assert property (p_odd) else $error("unmapped read not zero");
endmodule // bpe_port_ctrl_asserts

bind bpe_port_ctrl bpe_port_ctrl_asserts chk (.i_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
  .o_wired_net_xcvr_enable_n, .o_optical_xcvr_enable_n, .o_serial_port_one_enable_n,
  .o_serial_port_two_enable_n, .o_serial_rx_oe, .o_serial_carrier_detect, .o_serial_data_set_ready,
  .o_serial_clear_to_send, .o_card_port_enable_n, .o_card_in_buf_enable_n, .o_speaker_output_oe,
  .o_card_strobe_oe, .o_card_supply_select, .o_card_prog_supply_select);

/* verif/bpe_pin_model.sv */
// Purpose: Pin side model: optical transmit line, card socket, terminal
// Assumes: Bench sets the levels; model moves pins just after an edge
// Notes:   Presence contacts make and break one cycle apart
`timescale 1ns/1ps

module bpe_pin_model (
  input  wire logic       i_clk,
  input  wire logic       i_tx_level,
  input  wire logic       i_card_in,
  input  wire logic [1:0] i_sense_code,
  input  wire logic [1:0] i_dtr,
  output logic            o_optical_tx,
  output logic [1:0]      o_card_present_n,
  output logic [1:0]      o_card_voltage_sense_n,
  output logic [1:0]      o_serial_dtr
);
  initial begin
    o_optical_tx = 1'b0;
    o_card_present_n = 2'h3;
    o_card_voltage_sense_n = 2'h3;
    o_serial_dtr = 2'h0;
  end
  always @(posedge i_clk) begin
    o_optical_tx <= i_tx_level;
    o_card_present_n <= {o_card_present_n[0], !i_card_in};
    o_card_voltage_sense_n <= i_card_in ? i_sense_code : 2'h3;
    o_serial_dtr <= i_dtr;
  end
endmodule // bpe_pin_model

/* verif/bpe_port_ctrl_tb.sv */
// Purpose: Self-checking bench for the board port enable control
// Assumes: 10 MHz clock, control at 8'h04, status at 8'h08
// Notes:   Sense code and supply code for 5 V cards are arbitrary
`timescale 1ns/1ps
`include "bpe_defs.vh"

module bpe_port_ctrl_tb;
  localparam [7:0] CTL = `BPE_OFS_CTRL;
  localparam [7:0] STA = `BPE_OFS_STAT;
  localparam [1:0] FIVE_V = 2'h2;
  localparam [1:0] SUP5 = 2'h1;
  logic i_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, tx_lv = 1'b0, card_in = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic [1:0] sense = 2'h3, dtr = 2'h0;
  wire [31:0] o_rdata;
  wire i_optical_tx, o_wired_net_xcvr_enable_n, o_optical_xcvr_enable_n, o_optical_range_high;
  wire o_serial_port_one_enable_n, o_serial_port_two_enable_n, o_card_port_enable_n;
  wire o_card_in_buf_enable_n, o_speaker_output_oe, o_card_strobe_oe;
  wire [1:0] i_card_present_n, i_card_voltage_sense_n, i_serial_dtr, o_serial_rx_oe;
  wire [1:0] o_serial_carrier_detect, o_serial_data_set_ready, o_serial_clear_to_send;
  wire [1:0] o_card_supply_select, o_card_prog_supply_select;
  wire [4:0] en_n = {o_card_port_enable_n, o_serial_port_two_enable_n, o_serial_port_one_enable_n,
                     o_optical_xcvr_enable_n, o_wired_net_xcvr_enable_n};
  int mismatches = 0;
  int check_count = 0;

  bpe_port_ctrl dut (.i_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_optical_tx,
    .i_card_present_n, .i_card_voltage_sense_n, .i_serial_dtr, .o_wired_net_xcvr_enable_n,
    .o_optical_xcvr_enable_n, .o_optical_range_high, .o_serial_port_one_enable_n,
    .o_serial_port_two_enable_n, .o_serial_rx_oe, .o_serial_carrier_detect, .o_serial_data_set_ready,
    .o_serial_clear_to_send, .o_card_port_enable_n, .o_card_in_buf_enable_n, .o_speaker_output_oe,
    .o_card_strobe_oe, .o_card_supply_select, .o_card_prog_supply_select);
  bpe_pin_model pins (.i_clk, .i_tx_level(tx_lv), .i_card_in(card_in), .i_sense_code(sense),
    .i_dtr(dtr), .o_optical_tx(i_optical_tx), .o_card_present_n(i_card_present_n),
    .o_card_voltage_sense_n(i_card_voltage_sense_n), .o_serial_dtr(i_serial_dtr));

  always #50 i_clk = ~i_clk;

  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    d = o_rdata;
  endtask
  task settle;
    repeat (2) @(posedge i_clk);
    #1;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_enables;
    logic [31:0] d;
    logic [8:0] e;
    for (int i = 0; i < 5; i++) begin
      e = 9'h01f & ~(9'h001 << i);
      wr(CTL, {23'h0, e});
      settle();
      chk(en_n, e[4:0]);
      chk(o_serial_rx_oe, {30'h0, ~e[3:2]});
      chk({o_speaker_output_oe, o_card_in_buf_enable_n}, {~e[4], e[4]});
      rd(CTL, d);
      chk(d, {23'h0, e});
    end
    $display("t_enables done");
  endtask
  task t_reset;
    logic [31:0] d;
    @(posedge i_clk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    #1;
    chk({en_n, o_serial_rx_oe, o_card_strobe_oe}, 8'hf8);
    chk({o_serial_carrier_detect, o_serial_data_set_ready, o_serial_clear_to_send}, 6'h3f);
    rd(CTL, d);
    chk(d, 32'h1f);
    $display("t_reset done");
  endtask
  task t_range;
    logic [31:0] d;
    for (int lv = 0; lv < 2; lv++) begin
      wr(CTL, 32'h01f);
      tx_lv <= lv[0];
      repeat (5) @(posedge i_clk);
      wr(CTL, 32'h01d);
      settle();
      chk(o_optical_range_high, lv[0]);
      rd(STA, d);
      chk(d[7:6], {1'b1, lv[0]});
    end
    $display("t_range done");
  endtask
  task t_card;
    logic [31:0] d;
    wr(CTL, 32'h00f);
    sense <= FIVE_V;
    card_in <= 1'b1;
    repeat (8) @(posedge i_clk);
    rd(STA, d);
    chk({d[8], d[1:0]}, 3'h4);
    if (d[3:2] === FIVE_V) wr(CTL, {23'h0, 2'h1, SUP5, 5'h0f});
    settle();
    chk({o_card_strobe_oe, o_card_prog_supply_select, o_card_supply_select}, {1'b1, 2'h1, SUP5});
    wr(STA, 32'h100);
    card_in <= 1'b0;
    repeat (8) @(posedge i_clk);
    rd(STA, d);
    chk(d[9:8], 2'h2);
    wr(CTL, 32'h00f);
    settle();
    chk({o_card_strobe_oe, o_card_supply_select}, 3'h0);
    $display("t_card done");
  endtask
  task t_bus;
    logic [31:0] d;
    rd(8'h0c, d);
    chk(d, 32'h0);
    wr(8'h0c, 32'h0);
    rd(CTL, d);
    chk(d, 32'h00f);
    wr(CTL, 32'hffff_ffe0);
    rd(CTL, d);
    chk(d, 32'h1e0);
    dtr <= 2'h2;
    repeat (5) @(posedge i_clk);
    rd(STA, d);
    chk(d[5:4], 2'h2);
    $display("t_bus done");
  endtask

  initial begin
    repeat (100000) @(posedge i_clk);
    mismatches++;
    conclude();
  end
  initial begin
    repeat (10) @(posedge i_clk);
    i_rst <= 1'b0;
    t_enables();
    t_reset();
    t_range();
    t_card();
    t_bus();
    conclude();
  end
endmodule // bpe_port_ctrl_tb
